//--- osd_led_pulse.sv
`timescale 1ns/1ps
module osd_led_pulse #(
  parameter int PERIOD_CYC = 13000,
  parameter int ON_CYC = 800,
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_in, // System clock.
  input wire logic reset_in, // Asynchronous reset, active high.
  output logic led_out, // Emitter drive, high while lit.
  output logic on_smp_out, // Pulse in the last lit cycle.
  output logic off_smp_out // Pulse in the last dark cycle.
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] ON_L = CNT_W'(ON_CYC);
  localparam logic [CNT_W-1:0] ON_LAST = CNT_W'(ON_CYC - 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic led_r;
  logic on_smp_r;
  logic off_smp_r;

  if (ON_CYC < 4 || ON_CYC >= PERIOD_CYC - 4 ||
      PERIOD_CYC > (1 << CNT_W)) begin : g_chk
    $error("osd_led_pulse timing does not fit the counter");
  end

  assign cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;

  // Free-running period counter; the emitter never stops, so the receiver
  // always has a fresh comparison window. It rests on the last count in
  // reset, so the first lit window after release is a full one.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_r <= LAST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Flags are taken from the next count so they line up with cnt_r.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      led_r <= 1'b0;
      on_smp_r <= 1'b0;
      off_smp_r <= 1'b0;
    end else begin
      led_r <= (cnt_nxt < ON_L);
      on_smp_r <= (cnt_nxt == ON_LAST);
      off_smp_r <= (cnt_nxt == LAST);
    end
  end

  assign led_out = led_r;
  assign on_smp_out = on_smp_r;
  assign off_smp_out = off_smp_r;

endmodule

//--- osd_map.svh
`ifndef OSD_MAP_SVH
`define OSD_MAP_SVH

// Clock rate and emitter timing, in their own units.
`define OSD_CLK_MHZ 100
`define OSD_LED_PERIOD_US 130
`define OSD_LED_ON_US 8

// Register byte offsets.
`define OSD_REG_RESULT 8'h00
`define OSD_REG_CTRL 8'h04
`define OSD_REG_STATUS 8'h08
`define OSD_REG_IRQ_EN 8'h0C
`define OSD_REG_IRQ_CLR 8'h10

// Control field positions and reset values.
`define OSD_CTRL_EN_BIT 0
`define OSD_CTRL_LT_BIT 1
`define OSD_CTRL_EN_RST 1'h1
`define OSD_IRQ_EN_RST 3'h0

// Status and enable field positions.
`define OSD_EV_HIT_BIT 0
`define OSD_EV_NONE_BIT 1
`define OSD_EV_UNK_BIT 2
`define OSD_EV_W 3

// Result field positions.
`define OSD_RES_SIZE_LSB 0
`define OSD_RES_SIZE_MSB 3
`define OSD_RES_NONE_BIT 4
`define OSD_RES_PT_LSB 5
`define OSD_RES_PT_MSB 9
`define OSD_RES_PLATEN_BIT 10

// Sense point positions in the five-bit pattern.
`define OSD_PT_CENTER 4
`define OSD_PT_RIGHT 3
`define OSD_PT_A 2
`define OSD_PT_B 1
`define OSD_PT_C 0
`define OSD_PT_N 5

`endif

//--- osd_pkg.sv
package osd_pkg;

  // Recognised original sizes; NONE stands for the no-original state.
  typedef enum logic [3:0] {
    OSD_NONE = 4'h0,
    OSD_A3 = 4'h1,
    OSD_A4 = 4'h2,
    OSD_B4 = 4'h3,
    OSD_B5 = 4'h4,
    OSD_A4R = 4'h5,
    OSD_A5 = 4'h6,
    OSD_B5R = 4'h7,
    OSD_A5R = 4'h8,
    OSD_LD = 4'h9,
    OSD_LT = 4'hA,
    OSD_LG = 4'hB,
    OSD_LTR = 4'hC,
    OSD_ST = 4'hD,
    OSD_STR = 4'hE
  } osd_size_e;

  // Decoder answer: whether the pattern matched and which size.
  typedef struct packed {
    logic hit;
    osd_size_e size;
  } osd_dec_s;

  // Register port request, one cycle per access.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } osd_bus_req_s;

  // Pattern bits are center, right, a, b, c; a zero is an original.
  function automatic osd_dec_s osd_decode(input logic [4:0] pat,
                                          input logic lt_sel);
    osd_dec_s d;
    d.hit = 1'b1;
    d.size = OSD_NONE;
    if (lt_sel) begin
      case ({pat[4:3], pat[1:0]})
        4'h0: d.size = OSD_LD;
        4'h4: d.size = OSD_LT;
        4'h2: d.size = OSD_LG;
        4'h6: d.size = OSD_LTR;
        4'hE: d.size = OSD_ST;
        4'h7: d.size = OSD_STR;
        default: d.hit = 1'b0;
      endcase
    end else begin
      case (pat)
        5'h00: d.size = OSD_A3;
        5'h08: d.size = OSD_A4;
        5'h02: d.size = OSD_B4;
        5'h1A: d.size = OSD_B5;
        5'h06: d.size = OSD_A4R;
        5'h1E: d.size = OSD_A5;
        5'h07: d.size = OSD_B5R;
        5'h0F: d.size = OSD_A5R;
        default: d.hit = 1'b0;
      endcase
    end
    return d;
  endfunction

endpackage

//--- osd_sense_model.sv
`timescale 1ns/1ps
// Reflective receivers at the five detection points.
module osd_sense_model (
  input wire logic led_in, // Common emitter drive, high while lit.
  input wire logic [4:0] absent_in, // A one means no original there.
  input wire logic stuck_in, // Receivers held low, not pulsed.
  output logic [4:0] rx_out // Receiver levels, low on echo.
);
  // An original echoes the emitter pulse, so the line is low while lit.
  // A stuck receiver stays low, which the block must not take as an echo.
  // echo follows pulse
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      rx_out[i] = absent_in[i] ? 1'b1 : (stuck_in ? 1'b0 : ~led_in);
    end
  end
endmodule

//--- osd_sync2.sv
`timescale 1ns/1ps
module osd_sync2 #(
  parameter int W = 8
) (
  input wire logic clk_sys_in, // System clock.
  input wire logic reset_in, // Asynchronous reset, active high.
  input wire logic [W-1:0] async_in, // Levels from outside the domain.
  output logic [W-1:0] sync_out // Levels after two stages.
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  if (W < 1) begin : g_chk
    $error("osd_sync2 needs a width of at least one");
  end

  // Two stages; only the second stage reads the first. Both reset to all
  // ones, the idle level of every receiver, so reset shows no echo.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

//--- osd_top.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "osd_map.svh"
// Behaviour
// - The five-point pattern decodes to the eight large-series sizes.
// - The four-point pattern decodes to the six letter-series sizes.
// - An unmatched, not all-high pattern keeps the last result unchanged.
// - An all-high pattern gives the no-original state and no selection.
// - A matched pattern shows the size and requests a paper or ratio pick.
// - The pattern is evaluated every emitter period while platen is off.
// - While the platen sensor is on, the result is frozen.
// - A size change never moves the carriage; it stays at standby.
// - Emitters get a 130 us period pulse with an 8 us on time.
// - A point shows an original only if the echo follows the pulse.
// - Detection runs only in detection mode with carriage-1 at home.
module osd_top
  import osd_pkg::*;
#(
  parameter bit LT_SERIES = 1'b0,
  parameter int PERIOD_CYC = `OSD_LED_PERIOD_US * `OSD_CLK_MHZ,
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_in, // System clock, 100 MHz.
  input wire logic reset_in, // Asynchronous reset, active high.
  input wire logic [4:0] size_sense_rx_in, // Receivers, low on echo.
  input wire logic platen_on_in, // Platen sensor, high when on.
  input wire logic size_mode_in, // High in size detection mode.
  input wire logic carriage_home_in, // High with carriage-1 at home.
  input wire osd_pkg::osd_bus_req_s bus_req_in, // Register request.
  output logic [31:0] bus_rdata_out, // Read data, cycle after read.
  output logic led_drive_out, // Common emitter drive.
  output osd_pkg::osd_size_e size_out, // Reported size.
  output logic no_original_out, // High in the no-original state.
  output logic select_req_out, // Pulse: pick paper or ratio.
  output logic carriage_standby_out, // Carriage held at standby.
  output logic irq_out // Level interrupt.
);

  localparam int ON_CYC = `OSD_LED_ON_US * `OSD_CLK_MHZ;

  logic [4:0] rx_s;
  logic platen_s;
  logic mode_s;
  logic home_s;
  logic led;
  logic on_smp;
  logic off_smp;
  logic [4:0] seen_on_r;
  logic [4:0] pt_r;
  logic [4:0] pt_nxt;
  logic pat_vld_r;
  logic ctrl_en_r;
  logic ctrl_lt_r;
  logic [`OSD_EV_W-1:0] irq_en_r;
  logic [`OSD_EV_W-1:0] status_r;
  logic [`OSD_EV_W-1:0] ev;
  logic [31:0] rdata_r;
  osd_size_e size_r;
  logic none_r;
  logic sel_r;
  logic standby_r;
  logic gate;
  logic eval;
  logic all_high;
  osd_dec_s dec;

  if (PERIOD_CYC <= ON_CYC + 4) begin : g_chk
    $error("osd_top emitter period must exceed the on time");
  end

  osd_sync2 #(
    .W(8)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .async_in({size_sense_rx_in, platen_on_in, size_mode_in,
               carriage_home_in}),
    .sync_out({rx_s, platen_s, mode_s, home_s})
  );

  osd_led_pulse #(
    .PERIOD_CYC(PERIOD_CYC),
    .ON_CYC(ON_CYC),
    .CNT_W(CNT_W)
  ) u_led (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .led_out(led),
    .on_smp_out(on_smp),
    .off_smp_out(off_smp)
  );

  assign led_drive_out = led;

  // echo must follow pulse
  // Each point is sampled late in the lit window and again late in the dark
  // window; ambient light that holds the receiver low fails the dark check.
  // The two-stage delay is far shorter than either window.
  for (genvar i = 0; i < `OSD_PT_N; i++) begin : g_pt
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
        seen_on_r[i] <= 1'b0;
      end else if (on_smp) begin
        seen_on_r[i] <= ~rx_s[i];
      end
    end
    assign pt_nxt[i] = ~(seen_on_r[i] & rx_s[i]);
  end

  // Point pattern, refreshed once per emitter period; a one means no original.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pt_r <= 5'h1F;
      pat_vld_r <= 1'b0;
    end else begin
      pat_vld_r <= off_smp;
      if (off_smp) begin
        pt_r <= pt_nxt;
      end
    end
  end

  assign gate = ~platen_s & mode_s & home_s & ctrl_en_r;
  assign eval = pat_vld_r & gate;
  // The letter series has no point a, so that bit is ignored there.
  assign all_high = ctrl_lt_r ? (&{pt_r[4:3], pt_r[1:0]}) : (&pt_r);
  assign dec = osd_decode(pt_r, ctrl_lt_r);

  // Held result; only an evaluated pattern may change it.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      size_r <= OSD_NONE;
      none_r <= 1'b1;
      sel_r <= 1'b0;
    end else begin
      sel_r <= 1'b0;
      if (eval) begin
        if (all_high) begin
          size_r <= OSD_NONE;
          none_r <= 1'b1;
        end else if (dec.hit) begin
          size_r <= dec.size;
          none_r <= 1'b0;
          sel_r <= 1'b1;
        end
      end
    end
  end

  // carriage stays
  // The size path has no link to the carriage; this flag only tells the
  // motor controller that detection never asks it to move.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      standby_r <= 1'b1;
    end else begin
      standby_r <= 1'b1;
    end
  end

  assign size_out = size_r;
  assign no_original_out = none_r;
  assign select_req_out = sel_r;
  assign carriage_standby_out = standby_r;

  // Events seen by software.
  assign ev[`OSD_EV_HIT_BIT] = eval & ~all_high & dec.hit;
  assign ev[`OSD_EV_NONE_BIT] = eval & all_high;
  assign ev[`OSD_EV_UNK_BIT] = eval & ~all_high & ~dec.hit;

  // Control and interrupt enable registers.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_en_r <= `OSD_CTRL_EN_RST;
      ctrl_lt_r <= LT_SERIES;
      irq_en_r <= `OSD_IRQ_EN_RST;
    end else if (bus_req_in.wr) begin
      if (bus_req_in.addr == `OSD_REG_CTRL) begin
        ctrl_en_r <= bus_req_in.wdata[`OSD_CTRL_EN_BIT];
        ctrl_lt_r <= bus_req_in.wdata[`OSD_CTRL_LT_BIT];
      end
      if (bus_req_in.addr == `OSD_REG_IRQ_EN) begin
        irq_en_r <= bus_req_in.wdata[`OSD_EV_W-1:0];
      end
    end
  end

  // Sticky status; a new event in the clearing cycle survives the clear.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      status_r <= '0;
    end else if (bus_req_in.wr && bus_req_in.addr == `OSD_REG_IRQ_CLR) begin
      status_r <= (status_r & ~bus_req_in.wdata[`OSD_EV_W-1:0]) | ev;
    end else begin
      status_r <= status_r | ev;
    end
  end

  assign irq_out = |(status_r & irq_en_r);

  // Read data for one cycle after the strobe; unmapped and write-only
  // offsets read as zero.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (bus_req_in.rd) begin
        case (bus_req_in.addr)
          `OSD_REG_RESULT: begin
            rdata_r[`OSD_RES_SIZE_MSB:`OSD_RES_SIZE_LSB] <= size_r;
            rdata_r[`OSD_RES_NONE_BIT] <= none_r;
            rdata_r[`OSD_RES_PT_MSB:`OSD_RES_PT_LSB] <= pt_r;
            rdata_r[`OSD_RES_PLATEN_BIT] <= platen_s;
          end
          `OSD_REG_CTRL: begin
            rdata_r[`OSD_CTRL_EN_BIT] <= ctrl_en_r;
            rdata_r[`OSD_CTRL_LT_BIT] <= ctrl_lt_r;
          end
          `OSD_REG_STATUS: rdata_r[`OSD_EV_W-1:0] <= status_r;
          `OSD_REG_IRQ_EN: rdata_r[`OSD_EV_W-1:0] <= irq_en_r;
          default: rdata_r <= '0;
        endcase
      end
    end
  end

  assign bus_rdata_out = rdata_r;

  // Helper counters for emitter timing checks.
  logic [CNT_W-1:0] hi_run_r;
  logic [CNT_W-1:0] rise_gap_r;
  logic led_d_r;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      hi_run_r <= '0;
      rise_gap_r <= '0;
      led_d_r <= 1'b0;
    end else begin
      led_d_r <= led;
      hi_run_r <= led ? hi_run_r + 1'b1 : '0;
      rise_gap_r <= (led && !led_d_r) ? CNT_W'(1) : rise_gap_r + 1'b1;
    end
  end

  a_led_on_time: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (led_d_r && !led) |-> hi_run_r == CNT_W'(ON_CYC))
    else $error("Emitter on time is wrong.");

  a_led_period_len: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (led && !led_d_r && rise_gap_r != '0 && $past(rise_gap_r) != '0)
    |-> rise_gap_r == CNT_W'(PERIOD_CYC))
    else $error("Emitter period is wrong.");

  a_echo_needs_dark: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (off_smp && !rx_s[0]) |=> pt_r[0])
    else $error("Point taken as present without a dark echo.");

  a_freeze_platen: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (platen_s && $past(platen_s)) |=> $stable(size_r) && $stable(none_r))
    else $error("Result moved while platen is on.");

  a_none_all_high: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (eval && all_high) |=> size_r == OSD_NONE && none_r && !sel_r)
    else $error("All-high pattern did not give no-original.");

  a_hit_selects: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (eval && !all_high && dec.hit) |=> sel_r && size_r == $past(dec.size)
    ##1 !sel_r)
    else $error("Matched pattern did not show and select.");

  a_hold_unknown: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (eval && !all_high && !dec.hit) |=> $stable(size_r) && !sel_r)
    else $error("Unknown pattern changed the result.");

  a_mode_gate: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (!mode_s || !home_s) |=> $stable(size_r) && $stable(none_r))
    else $error("Result changed outside detection mode.");

  a_carriage_still: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    $changed(size_r) |-> carriage_standby_out ##1 carriage_standby_out)
    else $error("Carriage left standby on a size change.");

  a_irq_follows: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    (|(ev & irq_en_r) && !bus_req_in.wr) |=> irq_out)
    else $error("Enabled event raised no interrupt.");

  a_sel_needs_match: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    sel_r |-> $past(eval) && !$past(all_high) && $past(dec.hit))
    else $error("Selection pulse without a matched pattern.");

  a_pattern_period: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    $changed(pt_r) |-> $past(off_smp))
    else $error("Point pattern moved outside a period end.");

  // Status bits only fall through a clear write; software relies on that.
  a_status_sticky: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !($past(bus_req_in.wr) && $past(bus_req_in.addr) == `OSD_REG_IRQ_CLR)
    |-> (status_r & $past(status_r)) == $past(status_r))
    else $error("Status bit fell without a clear.");

  // Read data must return to zero so a stale word is never taken twice.
  a_rdata_idle_zero: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !$past(bus_req_in.rd) |-> bus_rdata_out == 32'h0)
    else $error("Read data showed without a read strobe.");

  c_size_found: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    sel_r);
  c_no_original: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    eval && all_high);
  c_frozen_change: cover property (@(posedge clk_sys_in)
    disable iff (reset_in) platen_s && pat_vld_r && pt_r != 5'h1F);
  c_irq_seen: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    irq_out);
  c_unknown_held: cover property (@(posedge clk_sys_in)
    disable iff (reset_in) eval && !all_high && !dec.hit);

endmodule

//--- tb.sv
`timescale 1ns/1ps
`include "osd_map.svh"
module tb;
  import osd_pkg::*;
  localparam int P = 900;
  typedef struct packed {
    logic lt;
    logic [4:0] pat;
    osd_size_e sz;
    logic none;
    logic sel;
  } osd_row_s;
  localparam osd_row_s ROWS [16] = '{
    '{1'b0, 5'h00, OSD_A3, 1'b0, 1'b1}, '{1'b0, 5'h08, OSD_A4, 1'b0, 1'b1},
    '{1'b0, 5'h02, OSD_B4, 1'b0, 1'b1}, '{1'b0, 5'h1A, OSD_B5, 1'b0, 1'b1},
    '{1'b0, 5'h06, OSD_A4R, 1'b0, 1'b1}, '{1'b0, 5'h1E, OSD_A5, 1'b0, 1'b1},
    '{1'b0, 5'h07, OSD_B5R, 1'b0, 1'b1}, '{1'b0, 5'h0F, OSD_A5R, 1'b0, 1'b1},
    '{1'b0, 5'h1F, OSD_NONE, 1'b1, 1'b0}, '{1'b1, 5'h04, OSD_LD, 1'b0, 1'b1},
    '{1'b1, 5'h08, OSD_LT, 1'b0, 1'b1}, '{1'b1, 5'h02, OSD_LG, 1'b0, 1'b1},
    '{1'b1, 5'h0E, OSD_LTR, 1'b0, 1'b1}, '{1'b1, 5'h1A, OSD_ST, 1'b0, 1'b1},
    '{1'b1, 5'h0B, OSD_STR, 1'b0, 1'b1}, '{1'b1, 5'h1F, OSD_NONE, 1'b1, 1'b0}
  };
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [4:0] rx;
  logic [4:0] absent = 5'h1F;
  logic stuck = 1'b0;
  logic platen_on = 1'b0;
  logic size_mode = 1'b1;
  logic carriage_home = 1'b1;
  osd_bus_req_s bus_req = '0;
  logic [31:0] bus_rdata;
  logic led_drive, no_original, select_req, carriage_standby, irq;
  osd_size_e size;
  int mismatches = 0;
  int n_compared = 0;
  int sel_cnt = 0;
  int cycles = 0;
  logic [31:0] rd_val;
  time t0, t1, t2;

  osd_top #(.LT_SERIES(1'b0), .PERIOD_CYC(P), .CNT_W(16)) osd_top_i (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .size_sense_rx_in(rx),
    .platen_on_in(platen_on), .size_mode_in(size_mode),
    .carriage_home_in(carriage_home), .bus_req_in(bus_req),
    .bus_rdata_out(bus_rdata), .led_drive_out(led_drive), .size_out(size),
    .no_original_out(no_original), .select_req_out(select_req),
    .carriage_standby_out(carriage_standby), .irq_out(irq));
  osd_sense_model osd_sense_model_i (.led_in(led_drive), .absent_in(absent),
    .stuck_in(stuck), .rx_out(rx));

  always #5 clk_sys_in = ~clk_sys_in;

  // Selection pulses are counted so a window can be judged as a whole.
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (select_req === 1'b1) sel_cnt <= sel_cnt + 1;
    if (cycles == 95000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_sz(input osd_size_e got, input osd_size_e exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t size got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_in) bus_req <= '0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe was taken.
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys_in) bus_req <= '0;
    #1 d = bus_rdata;
  endtask

  // Two periods let old patterns drain; the next P - 1 edges hold at most one
  // evaluation, so the pick count over them is zero or one.
  task automatic check_state(input osd_size_e sz, input logic none,
                             input logic sel);
    int s0;
    repeat (2 * P) @(posedge clk_sys_in);
    s0 = sel_cnt;
    repeat (P - 1) @(posedge clk_sys_in);
    #1;
    chk_sz(size, sz);
    chk32({31'h0, no_original}, {31'h0, none});
    chk32(sel_cnt - s0, {31'h0, sel});
    chk32({31'h0, carriage_standby}, 32'h1);
  endtask

  task automatic stop_test();
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check_reset();
    chk_sz(size, OSD_NONE);
    chk32({27'h0, led_drive, no_original, select_req, carriage_standby,
           irq}, 32'hA);
    chk32(bus_rdata, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_in);
    #1 check_reset();
    @(posedge clk_sys_in) reset_in <= 1'b0;
    // Table walk over both series, including ignored point a in letters.
    foreach (ROWS[i]) begin
      bus_wr(`OSD_REG_CTRL, {30'h0, ROWS[i].lt, 1'b1});
      @(posedge clk_sys_in) absent <= ROWS[i].pat;
      check_state(ROWS[i].sz, ROWS[i].none, ROWS[i].sel);
    end
    bus_wr(`OSD_REG_CTRL, 32'h1);
    @(posedge clk_sys_in) absent <= 5'h08;
    check_state(OSD_A4, 1'b0, 1'b1);
    @(posedge clk_sys_in) absent <= 5'h01;
    check_state(OSD_A4, 1'b0, 1'b0);
    @(posedge clk_sys_in) platen_on <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    absent <= 5'h00;
    check_state(OSD_A4, 1'b0, 1'b0);
    // Status is cleared while frozen, so only new events appear after.
    bus_wr(`OSD_REG_IRQ_CLR, 32'h7);
    bus_rd(`OSD_REG_STATUS, rd_val);
    chk32(rd_val, 32'h0);
    bus_wr(`OSD_REG_IRQ_EN, 32'h1);
    chk32({31'h0, irq}, 32'h0);
    @(posedge clk_sys_in) platen_on <= 1'b0;
    check_state(OSD_A3, 1'b0, 1'b1);
    bus_rd(`OSD_REG_STATUS, rd_val);
    chk32(rd_val, 32'h1);
    chk32({31'h0, irq}, 32'h1);
    bus_wr(`OSD_REG_IRQ_EN, 32'h2);
    chk32({31'h0, irq}, 32'h0);
    bus_rd(`OSD_REG_RESULT, rd_val);
    chk32(rd_val, 32'h1);
    bus_rd(8'h40, rd_val);
    chk32(rd_val, 32'h0);
    bus_rd(`OSD_REG_CTRL, rd_val);
    chk32(rd_val, 32'h1);
    bus_rd(`OSD_REG_IRQ_EN, rd_val);
    chk32(rd_val, 32'h2);
    // Leaving detection mode, or the carriage leaving home, holds all.
    @(posedge clk_sys_in) absent <= 5'h1A;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys_in) size_mode <= k[0];
      carriage_home <= ~k[0];
      check_state(OSD_A3, 1'b0, 1'b0);
    end
    @(posedge clk_sys_in) carriage_home <= 1'b1;
    check_state(OSD_B5, 1'b0, 1'b1);
    // Detection switched off by software holds the result as well.
    bus_wr(`OSD_REG_CTRL, 32'h0);
    @(posedge clk_sys_in) absent <= 5'h08;
    check_state(OSD_B5, 1'b0, 1'b0);
    bus_wr(`OSD_REG_CTRL, 32'h1);
    @(posedge clk_sys_in) stuck <= 1'b1;
    absent <= 5'h00;
    check_state(OSD_NONE, 1'b1, 1'b0);
    chk32({31'h0, irq}, 32'h1);
    @(posedge clk_sys_in) stuck <= 1'b0;
    // Emitter lit time and period, measured edge to edge.
    @(posedge led_drive) t0 = $time;
    @(negedge led_drive) t1 = $time;
    @(posedge led_drive) t2 = $time;
    chk32(32'((t1 - t0) / 10), 32'(`OSD_LED_ON_US * `OSD_CLK_MHZ));
    chk32(32'((t2 - t0) / 10), P);
    // A reset in mid-run must drop the held result at once.
    @(posedge clk_sys_in) reset_in <= 1'b1;
    #1 check_reset();
    repeat (4) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    stop_test();
  end
endmodule
